// ===== rtl/mmcp_pkg.sv
// Purpose: Shared constants for the modem mailbox command port.
// Assumes: 50 MHz system clock.
// Notes:   Opcodes sit in the top byte of the 24-bit command word.
package mmcp_pkg;
   localparam int unsigned CLK_HZ        = 50_000_000;
   localparam int unsigned SAMPLE_HZ     = 7200;
   localparam int unsigned BAUD_HZ       = 2400;
   localparam int unsigned BIT_HZ        = 9600;
   localparam int unsigned ATTN_CLEAR_NS = 800;
   localparam int unsigned CLK_NS        = 20;
   // Half periods of the generated clocks, rounded down.
   localparam int unsigned SAMPLE_HALF   = CLK_HZ / (2 * SAMPLE_HZ);
   localparam int unsigned BAUD_HALF     = CLK_HZ / (2 * BAUD_HZ);
   localparam int unsigned BIT_HALF      = CLK_HZ / (2 * BIT_HZ);
   localparam int unsigned ATTN_CLEAR_CYC = ATTN_CLEAR_NS / CLK_NS;
   // Terminal clock counts as static after two bit periods without an edge.
   localparam int unsigned TERM_IDLE_CYC = 4 * BIT_HALF;
   localparam int unsigned HANDSHAKE_CMD_BAUDS    = 64;
   localparam int unsigned RETRAIN_BAUDS = 32;
   localparam int          CNT_W         = 16;

   localparam logic [7:0]  OP_ADAPT_HOLD = 8'h14;
   localparam logic [7:0]  OP_TX_GAIN    = 8'h02;
   localparam logic [7:0]  OP_SEND_BYTE  = 8'h03;
   localparam logic [7:0]  OP_SEND_MORE  = 8'h01;
   localparam logic [23:0] CMD_HANDSHAKE = 24'h040000;
   localparam logic [23:0] CMD_INIT      = 24'h0600c0;
   localparam logic [23:0] CMD_NOP       = 24'h000000;
   localparam logic [23:0] CMD_RETRAIN   = 24'h050000;

   localparam logic [15:0] GAIN_RESET    = 16'h4000;
   localparam int          GAIN_FRAC     = 14;

   // Status byte layout.
   localparam int ST_HS_BUSY  = 7;
   localparam int ST_HS_FAIL  = 6;
   localparam int ST_RETRAIN  = 5;
   localparam int ST_XTRA     = 4;
   localparam int ST_KIND_A   = 3;
   localparam int ST_KIND_B   = 2;
   localparam int ST_HS_OK    = 1;

   typedef enum logic [1:0] {
      MMCP_DSP  = 2'b00,
      MMCP_ATTN = 2'b01,
      MMCP_XFER = 2'b11
   } mmcp_mb_e;
endpackage

// ===== rtl/mmcp_top.sv
// Purpose: Mailbox command port of a modem engine with command decode and clocks.
// Assumes: Host bus pins and link clocks are asynchronous and are synchronised here.
// Notes:   Data bus output enable is active low; the bus is driven only during host reads.
`timescale 1ns/1ns
`default_nettype none
module mmcp_top
   import mmcp_pkg::*;
#(
   parameter int unsigned TERM_IDLE = mmcp_pkg::TERM_IDLE_CYC
)(
   input  wire logic        clk,               // System clock, 50 MHz.
   input  wire logic        rst_n,             // Asynchronous reset, active low.
   input  wire logic        chip_select_n,     // Host chip select pin.
   input  wire logic        reg_select_n,      // Host register select pin.
   input  wire logic        read_not_write,    // Host direction pin, high reads.
   input  wire logic        bus_strobe_n,      // Host data strobe pin.
   input  wire logic [7:0]  data_in,           // Data bus level seen at the pins.
   output logic      [7:0]  data_out,          // Data bus drive value.
   output logic             data_oe_n,         // Data bus output enable, low drives.
   output logic             mailbox_attention_n, // Mailbox attention, active low.
   output logic             mailbox_owner_flag, // High while host owns the mailbox.
   input  wire logic        terminal_tx_clock, // Terminal transmit clock pin.
   input  wire logic        rx_bit_clock,      // Receive bit clock pin.
   input  wire logic        rx_data,           // Received data bit pin.
   input  wire logic        digital_loopback,  // Digital loopback mode select pin.
   input  wire logic        analog_loopback,   // Analog loopback mode select pin.
   output logic             sample_clock,      // 7200 Hz sampling clock.
   output logic             tx_baud_clock,     // 2400 Hz transmit baud clock.
   output logic             tx_bit_clock,      // Transmit bit clock.
   output logic             tx_data,           // Transmit serial data bit.
   input  wire logic [15:0] tx_sample,         // Transmit sample, signed.
   output logic      [15:0] tx_sample_scaled,  // Sample after gain.
   output logic             eq_freeze,         // Equaliser adaptation frozen.
   output logic             ec_freeze,         // Echo canceller adaptation frozen.
   output logic             echo_canc_enable,  // Echo canceller enable.
   output logic             descramble_inverse, // Descrambler set as scrambler inverse.
   output logic             handshake_busy,    // Handshake sequence in progress.
   output logic             retrain_busy,      // Retrain sequence in progress.
   output logic             extra_cycle        // Extra command cycle requested.
);
   import mmcp_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers.
   logic [8:0] pin_s1_r;
   logic [8:0] pin_s2_r;
   logic [7:0] din_s1_r;
   logic [7:0] din_s2_r;
   logic       strobe_d_r;
   logic       cs_n_s;
   logic       rs_n_s;
   logic       rd_s;
   logic       strobe_n_s;
   logic       term_s;
   logic       rx_bit_clock_s;
   logic       rxd_s;
   logic       dlb_s;
   logic       alb_s;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         // Bus control pins idle high; clocks and mode pins start low so no false edge follows reset.
         pin_s1_r <= 9'h1e0;
         pin_s2_r <= 9'h1e0;
         din_s1_r <= 8'h00;
         din_s2_r <= 8'h00;
      end
      else
      begin
         pin_s1_r <= {chip_select_n, reg_select_n, read_not_write, bus_strobe_n,
                      terminal_tx_clock, rx_bit_clock, rx_data, digital_loopback, analog_loopback};
         pin_s2_r <= pin_s1_r;
         din_s1_r <= data_in;
         din_s2_r <= din_s1_r;
      end
   end

   assign {cs_n_s, rs_n_s, rd_s, strobe_n_s, term_s, rx_bit_clock_s, rxd_s, dlb_s, alb_s} = pin_s2_r;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         strobe_d_r <= 1'b1;
      else
         strobe_d_r <= strobe_n_s;
   end

   logic access;
   assign access = strobe_d_r && !strobe_n_s && !cs_n_s;

   ////////////////////////////////////////////////////////////////////////////
   // Clock generation.
   function automatic logic half_done(input logic [CNT_W-1:0] cnt, input int unsigned half);
      half_done = (cnt == CNT_W'(half - 1));
   endfunction

   logic [CNT_W-1:0] smp_cnt_r;
   logic [CNT_W-1:0] baud_cnt_r;
   logic [CNT_W-1:0] bit_cnt_r;
   logic             free_bit_r;
   logic             baud_tick;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         smp_cnt_r     <= '0;
         baud_cnt_r    <= '0;
         bit_cnt_r     <= '0;
         sample_clock  <= 1'b0;
         tx_baud_clock <= 1'b0;
         free_bit_r    <= 1'b0;
      end
      else
      begin
         smp_cnt_r  <= half_done(smp_cnt_r, SAMPLE_HALF) ? '0 : smp_cnt_r + 1'b1;
         baud_cnt_r <= half_done(baud_cnt_r, BAUD_HALF) ? '0 : baud_cnt_r + 1'b1;
         bit_cnt_r  <= half_done(bit_cnt_r, BIT_HALF) ? '0 : bit_cnt_r + 1'b1;
         if (half_done(smp_cnt_r, SAMPLE_HALF))
            sample_clock <= !sample_clock;
         if (half_done(baud_cnt_r, BAUD_HALF))
            tx_baud_clock <= !tx_baud_clock;
         if (half_done(bit_cnt_r, BIT_HALF))
            free_bit_r <= !free_bit_r;
      end
   end

   assign baud_tick = half_done(baud_cnt_r, BAUD_HALF) && !tx_baud_clock;

   // Terminal clock activity watch; outside digital loopback a static pin lets the bit clock free-run.
   logic        term_d_r;
   logic [15:0] term_idle_r;
   logic        term_live;
   logic        bit_src;
   logic        bit_d_r;
   logic        bit_tick;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         term_d_r    <= 1'b0;
         term_idle_r <= '0;
         bit_d_r     <= 1'b0;
      end
      else
      begin
         term_d_r <= term_s;
         bit_d_r  <= bit_src;
         if (term_s != term_d_r)
            term_idle_r <= 16'(TERM_IDLE);
         else if (term_idle_r != '0)
            term_idle_r <= term_idle_r - 1'b1;
      end
   end

   assign term_live = (term_idle_r != '0);
   assign bit_src   = dlb_s ? rx_bit_clock_s : (term_live ? term_s : free_bit_r);
   assign bit_tick  = bit_src && !bit_d_r;
   assign tx_bit_clock = bit_d_r;

   ////////////////////////////////////////////////////////////////////////////
   // Mailbox ownership and host bus.
   mmcp_mb_e    mb_r;
   logic [23:0] cmd_in_r;
   logic [23:0] resp_out_r;
   logic [23:0] cmd_r;
   logic        cmd_new_r;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mb_r      <= MMCP_XFER;
         cmd_new_r <= 1'b0;
         cmd_r     <= CMD_NOP;
      end
      else
      begin
         cmd_new_r <= 1'b0;
         unique case (mb_r)
            MMCP_DSP:
               if (baud_tick)
                  mb_r <= MMCP_ATTN;
            MMCP_ATTN:
               if (access && rd_s && !rs_n_s)
                  mb_r <= MMCP_XFER;
            MMCP_XFER:
               if (access && rd_s && rs_n_s)
               begin
                  mb_r      <= MMCP_DSP;
                  cmd_r     <= cmd_in_r;
                  cmd_new_r <= 1'b1;
               end
         endcase
      end
   end

   assign mailbox_owner_flag  = (mb_r != MMCP_DSP);
   assign mailbox_attention_n = (mb_r != MMCP_ATTN);

   logic [23:0] resp_next;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cmd_in_r   <= CMD_NOP;
         resp_out_r <= '0;
         data_out   <= 8'h00;
      end
      else if (mb_r == MMCP_DSP && baud_tick)
         resp_out_r <= resp_next;
      else if (mb_r == MMCP_XFER && access && !rs_n_s)
      begin
         if (rd_s)
         begin
            data_out   <= resp_out_r[23:16];
            resp_out_r <= {resp_out_r[15:0], 8'h00};
         end
         else
            cmd_in_r <= {cmd_in_r[15:0], din_s2_r};
      end
   end

   // Drive the bus for the strobe of a data read only.
   logic drive_r;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         drive_r <= 1'b0;
      else if (mb_r == MMCP_XFER && access && rd_s && !rs_n_s)
         drive_r <= 1'b1;
      else if (strobe_n_s || cs_n_s)
         drive_r <= 1'b0;
   end

   assign data_oe_n = !drive_r;

   ////////////////////////////////////////////////////////////////////////////
   // Command decode.
   logic [7:0]  op;
   logic [15:0] gain_r;
   logic [7:0]  hs_cnt_r;
   logic [7:0]  rt_cnt_r;
   logic        hs_ok_r;
   logic        answer_r;

   assign op = cmd_r[23:16];

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         eq_freeze   <= 1'b0;
         ec_freeze   <= 1'b0;
         gain_r      <= GAIN_RESET;
         hs_cnt_r    <= '0;
         rt_cnt_r    <= '0;
         hs_ok_r     <= 1'b0;
         extra_cycle <= 1'b0;
         answer_r    <= 1'b0;
      end
      else if (cmd_new_r)
      begin
         extra_cycle <= (op == OP_SEND_MORE);
         answer_r    <= (op == OP_TX_GAIN);
         if (cmd_r == CMD_INIT)
         begin
            eq_freeze <= 1'b0;
            ec_freeze <= 1'b0;
            gain_r    <= GAIN_RESET;
            hs_cnt_r  <= '0;
            rt_cnt_r  <= '0;
            hs_ok_r   <= 1'b0;
         end
         else if (cmd_r == CMD_HANDSHAKE)
         begin
            hs_cnt_r <= 8'(HANDSHAKE_CMD_BAUDS);
            hs_ok_r  <= 1'b0;
         end
         else if (cmd_r == CMD_RETRAIN)
            rt_cnt_r <= 8'(RETRAIN_BAUDS);
         else if (op == OP_ADAPT_HOLD)
         begin
            eq_freeze <= cmd_r[8];
            ec_freeze <= cmd_r[9];
         end
         else if (op == OP_TX_GAIN)
            gain_r <= {cmd_r[7:0], cmd_r[15:8]};
      end
      else if (baud_tick)
      begin
         // No-op leaves these running untouched.
         if (hs_cnt_r != '0)
            hs_cnt_r <= hs_cnt_r - 1'b1;
         if (hs_cnt_r == 8'h01)
            hs_ok_r <= 1'b1;
         if (rt_cnt_r != '0)
            rt_cnt_r <= rt_cnt_r - 1'b1;
      end
   end

   assign handshake_busy = (hs_cnt_r != '0);
   assign retrain_busy   = (rt_cnt_r != '0);

   ////////////////////////////////////////////////////////////////////////////
   // Transmit serialiser, gain and loopback.
   logic [7:0] tx_sh_r;
   logic [3:0] tx_left_r;
   logic [7:0] rx_sh_r;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_sh_r   <= 8'hff;
         tx_left_r <= '0;
         tx_data   <= 1'b1;
         rx_sh_r   <= 8'h00;
      end
      else
      begin
         if (cmd_new_r && (op == OP_SEND_BYTE || op == OP_SEND_MORE))
         begin
            tx_sh_r   <= cmd_r[15:8];
            tx_left_r <= 4'h8;
         end
         else if (bit_tick)
         begin
            rx_sh_r <= {rxd_s, rx_sh_r[7:1]};
            if (dlb_s)
               tx_data <= rxd_s;
            else if (tx_left_r != '0)
            begin
               tx_data   <= tx_sh_r[0];
               tx_sh_r   <= {1'b1, tx_sh_r[7:1]};
               tx_left_r <= tx_left_r - 1'b1;
            end
            else
               tx_data <= 1'b1;
         end
      end
   end

   logic signed [31:0] prod;
   assign prod = $signed(tx_sample) * $signed(gain_r);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_sample_scaled   <= 16'h0000;
         echo_canc_enable   <= 1'b1;
         descramble_inverse <= 1'b0;
      end
      else
      begin
         tx_sample_scaled   <= prod[GAIN_FRAC+15:GAIN_FRAC];
         echo_canc_enable   <= 1'b1;
         descramble_inverse <= alb_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Response assembly.
   logic [7:0] status;

   always_comb
   begin
      status              = 8'h00;
      status[ST_HS_BUSY]  = handshake_busy;
      status[ST_RETRAIN]  = retrain_busy;
      status[ST_XTRA]     = extra_cycle;
      status[ST_HS_OK]    = hs_ok_r;
      status[ST_KIND_A]   = answer_r;
      status[ST_KIND_B]   = 1'b1;
      if (answer_r)
         resp_next = {status, gain_r[7:0], gain_r[15:8]};
      else
         resp_next = {status, rx_sh_r, {6'h00, ec_freeze, eq_freeze}};
   end
endmodule
`default_nettype wire

// ===== testbench/mmcp_host_model.sv
// Purpose: Behavioural control processor on the mailbox bus.
// Assumes: Strobe held six cycles, at least three idle cycles between accesses.
// Notes:   The bus has no pull, so a released bus toggles every cycle.
`timescale 1ns/1ns
`default_nettype none
module mmcp_host_model (
   input  wire logic       clk,                 // Clock.
   input  wire logic [7:0] data_out,            // Device drive value.
   input  wire logic       data_oe_n,           // Device enable.
   input  wire logic       mailbox_attention_n, // Attention.
   output logic            chip_select_n,       // Select.
   output logic            reg_select_n,        // Register select.
   output logic            read_not_write,      // Direction.
   output logic            bus_strobe_n,        // Strobe.
   output logic      [7:0] data_in              // Bus level.
);
   logic [7:0] wr_r = 8'h00;
   logic       drv_r = 1'b0;
   logic [7:0] last_r = 8'h00;
   initial
   begin
      {chip_select_n, reg_select_n, read_not_write, bus_strobe_n} = 4'hf;
   end
   assign data_in = !data_oe_n ? data_out : (drv_r ? wr_r : ~last_r);
   always @(posedge clk)
      last_r <= data_in;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic access(input logic rs, input logic rd, input logic [7:0] wd, output logic [7:0] rb);
      @(posedge clk);
      chip_select_n <= 1'b0;
      reg_select_n <= rs;
      read_not_write <= rd;
      bus_strobe_n <= 1'b0;
      wr_r <= wd;
      drv_r <= !rd;
      repeat (6) @(posedge clk);
      rb = data_in;
      chip_select_n <= 1'b1;
      bus_strobe_n <= 1'b1;
      drv_r <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task automatic exchange(input logic opening, input logic [23:0] cmd, output logic [23:0] resp);
      logic [7:0] b;
      if (opening)
         access(1'b0, 1'b1, 8'h00, b);
      for (int i = 0; i < 3; i++)
         access(1'b0, 1'b0, cmd[23-8*i -: 8], b);
      for (int i = 0; i < 3; i++)
      begin
         access(1'b0, 1'b1, 8'h00, b);
         resp[23-8*i -: 8] = b;
      end
      access(1'b1, 1'b1, 8'h00, b);
   endtask
endmodule
`default_nettype wire

// ===== testbench/mmcp_properties.sv
// Purpose: Port properties of the mailbox command port.
// Assumes: Host pins are seen raw, some cycles ahead of the design.
// Notes:   Bound into the top module after the checker.
`timescale 1ns/1ns
`default_nettype none
module mmcp_properties
   import mmcp_pkg::*;
(
   input wire logic clk,                 // Clock.
   input wire logic rst_n,               // Reset.
   input wire logic chip_select_n,       // Select.
   input wire logic reg_select_n,        // Register select.
   input wire logic read_not_write,      // Direction.
   input wire logic bus_strobe_n,        // Strobe.
   input wire logic data_oe_n,           // Bus enable.
   input wire logic mailbox_attention_n, // Attention.
   input wire logic mailbox_owner_flag,  // Owner.
   input wire logic tx_baud_clock,       // Baud clock.
   input wire logic eq_freeze,           // Equaliser hold.
   input wire logic ec_freeze            // Echo hold.
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic        close_pins;
   logic        baud_prev_r;
   logic        baud_seen_r;
   logic [15:0] baud_cnt_r;
   assign close_pins = !bus_strobe_n && !chip_select_n && reg_select_n && read_not_write;
   // Counts cycles between baud clock edges; the first edge only arms it.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         baud_prev_r <= 1'b0;
         baud_seen_r <= 1'b0;
         baud_cnt_r  <= 16'h0000;
      end
      else
      begin
         baud_prev_r <= tx_baud_clock;
         baud_cnt_r  <= (tx_baud_clock != baud_prev_r) ? 16'h0001 : baud_cnt_r + 16'h0001;
         if (tx_baud_clock != baud_prev_r)
            baud_seen_r <= 1'b1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   sequence open_rd;
      $fell(bus_strobe_n) && !chip_select_n && !reg_select_n && read_not_write && !mailbox_attention_n;
   endsequence
   sequence close_rd;
      $fell(bus_strobe_n) && close_pins && mailbox_owner_flag && mailbox_attention_n;
   endsequence
   attn_owner_a: assert property (!mailbox_attention_n |-> mailbox_owner_flag)
      else $error("Attention low while the mailbox is not offered.");
   attn_clear_a: assert property (open_rd |-> ##[1:40] mailbox_attention_n)
      else $error("Attention still low 800 ns after the opening read.");
   close_clear_a: assert property (close_rd |-> ##[1:8] !mailbox_owner_flag)
      else $error("Owner flag not cleared by the closing read.");
   owner_release_a: assert property ($fell(mailbox_owner_flag) |-> $past(close_pins, 2))
      else $error("Owner flag cleared without a closing read.");
   attn_baud_a: assert property ($fell(mailbox_attention_n) |-> ##[0:2] tx_baud_clock)
      else $error("Attention raised away from a baud tick.");
   oe_read_a: assert property (!data_oe_n |-> $past(read_not_write, 3) && !$past(chip_select_n, 3))
      else $error("Data bus driven outside a host read.");
   freeze_owner_a: assert property (($changed(eq_freeze) || $changed(ec_freeze)) |-> !$past(mailbox_owner_flag))
      else $error("Freeze state changed while the host owns the mailbox.");
   baud_period_a: assert property ((baud_seen_r && tx_baud_clock != baud_prev_r) |-> baud_cnt_r == 16'(BAUD_HALF))
      else $error("Baud clock half period wrong.");
endmodule
bind mmcp_top mmcp_properties u_props (.clk, .rst_n, .chip_select_n, .reg_select_n, .read_not_write,
   .bus_strobe_n, .data_oe_n, .mailbox_attention_n, .mailbox_owner_flag, .tx_baud_clock, .eq_freeze, .ec_freeze);
`default_nettype wire

// ===== testbench/test_modem_mailbox_command_port.sv
// Purpose: Self-checking bench for the mailbox command port.
// Assumes: Each exchange but the first waits for the next baud tick; the first starts at once.
// Notes:   Terminal and receive clocks stay static, so transmit clocks free-run.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin error_cnt++; $display("MISMATCH %s exp %h got %h", nm, exp, got); end end
module test_modem_mailbox_command_port;
   import mmcp_pkg::*;
   logic        clk, rst_n, chip_select_n, reg_select_n, read_not_write, bus_strobe_n;
   logic [7:0]  data_in, data_out;
   logic        data_oe_n, mailbox_attention_n, mailbox_owner_flag, sample_clock, tx_baud_clock;
   logic        tx_bit_clock, tx_data, eq_freeze, ec_freeze, echo_canc_enable, descramble_inverse;
   logic        handshake_busy, retrain_busy, extra_cycle;
   logic        terminal_tx_clock = 1'b0, rx_bit_clock = 1'b0, rx_data = 1'b0;
   logic        digital_loopback = 1'b0, analog_loopback = 1'b0;
   logic [15:0] tx_sample = 16'h1000;
   logic [15:0] tx_sample_scaled;
   logic [23:0] resp;
   int          error_cnt = 0;
   int          total_checks = 0;
   mmcp_top #(.TERM_IDLE(64)) dut (.clk, .rst_n, .chip_select_n, .reg_select_n, .read_not_write,
      .bus_strobe_n, .data_in, .data_out, .data_oe_n, .mailbox_attention_n, .mailbox_owner_flag,
      .terminal_tx_clock, .rx_bit_clock, .rx_data, .digital_loopback, .analog_loopback, .sample_clock,
      .tx_baud_clock, .tx_bit_clock, .tx_data, .tx_sample, .tx_sample_scaled, .eq_freeze, .ec_freeze,
      .echo_canc_enable, .descramble_inverse, .handshake_busy, .retrain_busy, .extra_cycle);
   mmcp_host_model host (.clk, .data_out, .data_oe_n, .mailbox_attention_n, .chip_select_n,
      .reg_select_n, .read_not_write, .bus_strobe_n, .data_in);
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      if (error_cnt == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic cycle(input logic opening, input logic [23:0] cmd);
      int n;
      n = 0;
      while (opening && mailbox_attention_n !== 1'b0 && n < 25000)
      begin
         @(posedge clk);
         n++;
      end
      `CHK("attention owner", {~opening, 1'b1}, {mailbox_attention_n, mailbox_owner_flag})
      host.exchange(opening, cmd, resp);
      `CHK("attention after open", 1'b1, mailbox_attention_n)
      repeat (8) @(posedge clk);
      `CHK("owner after close", 1'b0, mailbox_owner_flag)
   endtask
   task automatic after_reset();
      `CHK("oe idle", 1'b1, data_oe_n)
      `CHK("echo on", 1'b1, echo_canc_enable)
      `CHK("unity gain", 16'h1000, tx_sample_scaled)
   endtask
   task automatic freeze_first();
      cycle(1'b0, {OP_ADAPT_HOLD, 8'h03, 8'h00});
      `CHK("freezes", 2'b11, {eq_freeze, ec_freeze})
   endtask
   task automatic gain_set();
      cycle(1'b1, {OP_TX_GAIN, 8'h00, 8'h20});
      `CHK("status kind", 2'b01, {resp[16+ST_KIND_A], resp[16+ST_KIND_B]})
      `CHK("freeze status", 8'h03, resp[7:0])
      `CHK("scaled", 16'h0800, tx_sample_scaled)
   endtask
   task automatic handshake_go();
      cycle(1'b1, CMD_HANDSHAKE);
      `CHK("answer kind", 2'b11, {resp[16+ST_KIND_A], resp[16+ST_KIND_B]})
      `CHK("gain answer", 16'h0020, resp[15:0])
      `CHK("hs busy", 1'b1, handshake_busy)
   endtask
   task automatic send_more();
      logic [7:0] sent;
      sent = 8'ha5;
      analog_loopback <= 1'b1;
      cycle(1'b1, {OP_SEND_MORE, sent, 8'h00});
      `CHK("hs status", 1'b1, resp[16+ST_HS_BUSY])
      `CHK("extra", 1'b1, extra_cycle)
      `CHK("descrambler", 1'b1, descramble_inverse)
      // The first two bits leave least significant first; the second is low, unlike the idle level.
      for (int i = 0; i < 2; i++)
      begin
         @(posedge tx_bit_clock);
         @(negedge clk);
         `CHK("tx bit", sent[i], tx_data)
      end
   endtask
   task automatic retrain_go();
      cycle(1'b1, CMD_RETRAIN);
      `CHK("init status", 8'h04, resp[23:16])
      `CHK("rt busy", 1'b1, retrain_busy)
   endtask
   task automatic init_all();
      cycle(1'b1, CMD_INIT);
      `CHK("extra status", 1'b1, resp[16+ST_XTRA])
      `CHK("hs cleared", 1'b0, handshake_busy)
      `CHK("freezes cleared", 2'b00, {eq_freeze, ec_freeze})
      `CHK("gain default", 16'h1000, tx_sample_scaled)
   endtask
   initial
   begin
      rst_n = 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      after_reset();
      freeze_first();
      gain_set();
      handshake_go();
      send_more();
      init_all();
      retrain_go();
      conclude();
   end
   initial
   begin
      repeat (100000) @(posedge clk);
      error_cnt++;
      conclude();
   end
endmodule
`default_nettype wire
